/* afc_coeff_regs.v */
// filter-coefficient register bank, second register page, numbers 52..70
// assumes the control-bus engine on clk decodes page and register number
`include "afc_consts.vh"

module afc_coeff_regs (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // register port from the control-bus engine
   input  wire        reg_page_sel,
   input  wire        reg_wr_en,
   input  wire        reg_rd_en,
   input  wire [6:0]  reg_addr,
   input  wire [7:0]  reg_wr_data,
   output wire        reg_hit,
   output wire [7:0]  reg_rd_data,
   output wire        reg_rd_valid,
   output wire        reg_wr_refused,
   // coefficients to the filter datapaths
   output wire [7:0]  right_deemph_den1_low,
   output wire [15:0] stereo_widening_atten,
   output wire [15:0] left_hpf_numerator_zero,
   output wire [15:0] left_hpf_numerator_one,
   output wire [15:0] left_hpf_denominator_one,
   output wire [4:0]  coeff_updated
);

   // true when addr lies in [first, last]
   function in_span;
      input [6:0] addr;
      input [6:0] first;
      input [6:0] last;
      begin
         in_span = (addr >= first) && (addr <= last);
      end
   endfunction

   // write strobe for one register number
   function wr_at;
      input       go;
      input [6:0] addr;
      input [6:0] target;
      begin
         wr_at = go && (addr == target);
      end
   endfunction

   wire       bank_sel;
   wire       rsvd_sel;
   wire       wr_go;
   wire       rd_go;
   wire       wr_rsvd;
   reg  [7:0] rd_value;
   reg  [7:0] rde_den1_lo_reg;
   reg        rde_upd_reg;

   wire [7:0] atten_hi;
   wire [7:0] atten_lo;
   wire [7:0] num0_hi;
   wire [7:0] num0_lo;
   wire [7:0] num1_hi;
   wire [7:0] num1_lo;
   wire [7:0] den1_hi;
   wire [7:0] den1_lo;
   wire       atten_upd;
   wire       num0_upd;
   wire       num1_upd;
   wire       den1_upd;

   // decode; addresses outside the bank belong to neighbouring banks
   assign bank_sel = reg_page_sel &&
                     in_span(reg_addr, `AFC_ADDR_BANK_FIRST,
                             `AFC_ADDR_BANK_LAST);
   assign rsvd_sel = reg_page_sel &&
                     in_span(reg_addr, `AFC_ADDR_RSVD_FIRST,
                             `AFC_ADDR_RSVD_LAST);
   assign reg_hit  = bank_sel;
   // a stray write to the reserved span is dropped, never stored
   assign wr_go    = reg_wr_en && bank_sel && !rsvd_sel;
   assign wr_rsvd  = reg_wr_en && rsvd_sel;
   assign rd_go    = reg_rd_en && bank_sel;

   // lone de-emphasis low byte; its high byte lives in the previous bank
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rde_den1_lo_reg <= `AFC_RST_RDE_DEN1_LO;
         rde_upd_reg     <= 1'b0;
      end else begin
         if (wr_at(wr_go, reg_addr, `AFC_ADDR_RDE_DEN1_LO))
            rde_den1_lo_reg <= reg_wr_data;
         rde_upd_reg <= wr_at(wr_go, reg_addr, `AFC_ADDR_RDE_DEN1_LO);
      end
   end

   afc_coef_pair #(
      .RST_HIGH (`AFC_RST_ATTEN_HI),
      .RST_LOW  (`AFC_RST_ATTEN_LO)
   ) u_atten (
      .clk         (clk),
      .reset_n     (reset_n),
      .wr_high     (wr_at(wr_go, reg_addr, `AFC_ADDR_ATTEN_HI)),
      .wr_low      (wr_at(wr_go, reg_addr, `AFC_ADDR_ATTEN_LO)),
      .wr_data     (reg_wr_data),
      .high_byte   (atten_hi),
      .low_byte    (atten_lo),
      .coeff       (stereo_widening_atten),
      .updated_reg (atten_upd)
   );

   afc_coef_pair #(
      .RST_HIGH (`AFC_RST_HPF_NUM0_HI),
      .RST_LOW  (`AFC_RST_HPF_NUM0_LO)
   ) u_num0 (
      .clk         (clk),
      .reset_n     (reset_n),
      .wr_high     (wr_at(wr_go, reg_addr, `AFC_ADDR_HPF_NUM0_HI)),
      .wr_low      (wr_at(wr_go, reg_addr, `AFC_ADDR_HPF_NUM0_LO)),
      .wr_data     (reg_wr_data),
      .high_byte   (num0_hi),
      .low_byte    (num0_lo),
      .coeff       (left_hpf_numerator_zero),
      .updated_reg (num0_upd)
   );

   afc_coef_pair #(
      .RST_HIGH (`AFC_RST_HPF_NUM1_HI),
      .RST_LOW  (`AFC_RST_HPF_NUM1_LO)
   ) u_num1 (
      .clk         (clk),
      .reset_n     (reset_n),
      .wr_high     (wr_at(wr_go, reg_addr, `AFC_ADDR_HPF_NUM1_HI)),
      .wr_low      (wr_at(wr_go, reg_addr, `AFC_ADDR_HPF_NUM1_LO)),
      .wr_data     (reg_wr_data),
      .high_byte   (num1_hi),
      .low_byte    (num1_lo),
      .coeff       (left_hpf_numerator_one),
      .updated_reg (num1_upd)
   );

   afc_coef_pair #(
      .RST_HIGH (`AFC_RST_HPF_DEN1_HI),
      .RST_LOW  (`AFC_RST_HPF_DEN1_LO)
   ) u_den1 (
      .clk         (clk),
      .reset_n     (reset_n),
      .wr_high     (wr_at(wr_go, reg_addr, `AFC_ADDR_HPF_DEN1_HI)),
      .wr_low      (wr_at(wr_go, reg_addr, `AFC_ADDR_HPF_DEN1_LO)),
      .wr_data     (reg_wr_data),
      .high_byte   (den1_hi),
      .low_byte    (den1_lo),
      .coeff       (left_hpf_denominator_one),
      .updated_reg (den1_upd)
   );

   // read mux; reserved numbers fall to the default and read zero
   always @* begin
      case (reg_addr)
         `AFC_ADDR_RDE_DEN1_LO: rd_value = rde_den1_lo_reg;
         `AFC_ADDR_ATTEN_HI:    rd_value = atten_hi;
         `AFC_ADDR_ATTEN_LO:    rd_value = atten_lo;
         `AFC_ADDR_HPF_NUM0_HI: rd_value = num0_hi;
         `AFC_ADDR_HPF_NUM0_LO: rd_value = num0_lo;
         `AFC_ADDR_HPF_NUM1_HI: rd_value = num1_hi;
         `AFC_ADDR_HPF_NUM1_LO: rd_value = num1_lo;
         `AFC_ADDR_HPF_DEN1_HI: rd_value = den1_hi;
         `AFC_ADDR_HPF_DEN1_LO: rd_value = den1_lo;
         default:               rd_value = `AFC_RSVD_VALUE;
      endcase
   end

   afc_rd_port u_rd_port (
      .clk            (clk),
      .reset_n        (reset_n),
      .rd_go          (rd_go),
      .rd_value       (rd_value),
      .wr_rsvd        (wr_rsvd),
      .rd_data_reg    (reg_rd_data),
      .rd_valid_reg   (reg_rd_valid),
      .wr_refused_reg (reg_wr_refused)
   );

   assign right_deemph_den1_low = rde_den1_lo_reg;

   // one-cycle pulses tell the datapath a coefficient byte was written
   assign coeff_updated[`AFC_UPD_RDE_DEN1] = rde_upd_reg;
   assign coeff_updated[`AFC_UPD_ATTEN]    = atten_upd;
   assign coeff_updated[`AFC_UPD_HPF_NUM0] = num0_upd;
   assign coeff_updated[`AFC_UPD_HPF_NUM1] = num1_upd;
   assign coeff_updated[`AFC_UPD_HPF_DEN1] = den1_upd;

endmodule // afc_coeff_regs

/* afc_consts.vh */
// constants for the filter-coefficient register bank on the second page
// assumes it is included by every design file of the bank, by bare name
`ifndef AFC_CONSTS_VH
`define AFC_CONSTS_VH

// register port geometry
`define AFC_ADDR_W            7
`define AFC_DATA_W            8
`define AFC_COEF_W            16

// register numbers on the second page
`define AFC_ADDR_RDE_DEN1_LO  7'h34
`define AFC_ADDR_ATTEN_HI     7'h35
`define AFC_ADDR_ATTEN_LO     7'h36
`define AFC_ADDR_RSVD_FIRST   7'h37
`define AFC_ADDR_RSVD_LAST    7'h40
`define AFC_ADDR_HPF_NUM0_HI  7'h41
`define AFC_ADDR_HPF_NUM0_LO  7'h42
`define AFC_ADDR_HPF_NUM1_HI  7'h43
`define AFC_ADDR_HPF_NUM1_LO  7'h44
`define AFC_ADDR_HPF_DEN1_HI  7'h45
`define AFC_ADDR_HPF_DEN1_LO  7'h46
`define AFC_ADDR_BANK_FIRST   7'h34
`define AFC_ADDR_BANK_LAST    7'h46

// reset values
`define AFC_RST_RDE_DEN1_LO   8'h7E
`define AFC_RST_ATTEN_HI      8'h7F
`define AFC_RST_ATTEN_LO      8'hFF
`define AFC_RST_HPF_NUM0_HI   8'h39
`define AFC_RST_HPF_NUM0_LO   8'h55
`define AFC_RST_HPF_NUM1_HI   8'hF3
`define AFC_RST_HPF_NUM1_LO   8'h2D
`define AFC_RST_HPF_DEN1_HI   8'h53
`define AFC_RST_HPF_DEN1_LO   8'h7E
`define AFC_RSVD_VALUE        8'h00

// bit positions of the coefficient-update pulse vector
`define AFC_UPD_RDE_DEN1      0
`define AFC_UPD_ATTEN         1
`define AFC_UPD_HPF_NUM0      2
`define AFC_UPD_HPF_NUM1      3
`define AFC_UPD_HPF_DEN1      4
`define AFC_UPD_W             5

`endif

/* afc_coef_pair.v */
// one 16-bit coefficient held as a high byte and a low byte register
// assumes write strobes are single-cycle and already decoded by the bank
`include "afc_consts.vh"

module afc_coef_pair #(
   parameter [7:0] RST_HIGH = 8'h00,
   parameter [7:0] RST_LOW  = 8'h00
) (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // byte writes
   input  wire        wr_high,
   input  wire        wr_low,
   input  wire [7:0]  wr_data,
   // stored bytes and joined value
   output wire [7:0]  high_byte,
   output wire [7:0]  low_byte,
   output wire [15:0] coeff,
   output reg         updated_reg
);

   reg [7:0] high_reg;
   reg [7:0] low_reg;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         high_reg    <= RST_HIGH;
         low_reg     <= RST_LOW;
         updated_reg <= 1'b0;
      end else begin
         if (wr_high)
            high_reg <= wr_data;
         if (wr_low)
            low_reg  <= wr_data;
         updated_reg <= wr_high | wr_low;
      end
   end

   assign high_byte = high_reg;
   assign low_byte  = low_reg;
   // two's-complement, high byte carries the sign
   assign coeff     = {high_reg, low_reg};

endmodule // afc_coef_pair

/* afc_rd_port.v */
// registered answer stage of the bank's register port
// assumes read and write strobes come from logic on the same clock
`include "afc_consts.vh"

module afc_rd_port (
   // clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // decoded request
   input  wire       rd_go,
   input  wire [7:0] rd_value,
   input  wire       wr_rsvd,
   // answer
   output reg  [7:0] rd_data_reg,
   output reg        rd_valid_reg,
   output reg        wr_refused_reg
);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_reg    <= `AFC_RSVD_VALUE;
         rd_valid_reg   <= 1'b0;
         wr_refused_reg <= 1'b0;
      end else begin
         // data holds between reads so a slow control engine can sample late
         if (rd_go)
            rd_data_reg <= rd_value;
         rd_valid_reg   <= rd_go;
         wr_refused_reg <= wr_rsvd;
      end
   end

endmodule // afc_rd_port

/* afc_chk_properties.sv */
// checker for the filter-coefficient register bank ports
// assumes it is bound onto afc_coeff_regs by tb_top
module afc_chk (
   // clock and reset
   input logic        clk,
   input logic        reset_n,
   // register port
   input logic        reg_page_sel,
   input logic        reg_wr_en,
   input logic        reg_rd_en,
   input logic [6:0]  reg_addr,
   input logic [7:0]  reg_wr_data,
   input logic        reg_hit,
   input logic [7:0]  reg_rd_data,
   input logic        reg_rd_valid,
   input logic        reg_wr_refused,
   // coefficients
   input logic [7:0]  right_deemph_den1_low,
   input logic [15:0] stereo_widening_atten,
   input logic [15:0] left_hpf_numerator_zero,
   input logic [15:0] left_hpf_numerator_one,
   input logic [15:0] left_hpf_denominator_one,
   input logic [4:0]  coeff_updated
);
   logic rsvd, wr, rd;
   logic [71:0] coefs;
   assign rsvd = reg_addr >= 7'h37 && reg_addr <= 7'h40;
   assign wr = reg_wr_en && reg_page_sel;
   assign rd = reg_rd_en && reg_hit;
   // every coefficient output, so a stray store anywhere shows up
   assign coefs = {right_deemph_den1_low, stereo_widening_atten,
      left_hpf_numerator_zero, left_hpf_numerator_one,
      left_hpf_denominator_one};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_hit_decode: assert property (reg_hit == (reg_page_sel
      && reg_addr >= 7'h34 && reg_addr <= 7'h46)) else $error("hit wrong");
   a_rd_valid_due: assert property (rd |=> reg_rd_valid)
      else $error("read got no valid");
   a_rd_valid_idle: assert property (!rd |=> !reg_rd_valid)
      else $error("stray valid");
   a_rsvd_reads_zero: assert property (rd && rsvd |=>
      reg_rd_data == 8'h00) else $error("reserved read not zero");
   a_rsvd_write_drop: assert property (wr && rsvd |=> reg_wr_refused
      && $stable(coefs) && coeff_updated == 5'h00) else $error("rsvd write");
   a_atten_high_wr: assert property (wr && reg_addr == 7'h35 |=>
      stereo_widening_atten[15:8] == $past(reg_wr_data) && coeff_updated[1])
      else $error("atten high byte not stored");
   a_den1_low_wr: assert property (wr && reg_addr == 7'h46 |=>
      left_hpf_denominator_one[7:0] == $past(reg_wr_data))
      else $error("den1 low byte not stored");
   a_coef_hold: assert property (!wr |=> $stable(coefs)
      && coeff_updated == 5'h00) else $error("coefficient moved");
   a_rd_data_hold: assert property (!rd |=> $stable(reg_rd_data))
      else $error("read data moved");
   a_refuse_rsvd_only: assert property (!(wr && rsvd) |=>
      !reg_wr_refused) else $error("stray refusal");
   a_num1_low_wr: assert property (wr && reg_addr == 7'h44 |=>
      left_hpf_numerator_one[7:0] == $past(reg_wr_data) && coeff_updated[3])
      else $error("num1 low byte not stored");
   c_rsvd_read: cover property (rd && rsvd);
   c_rsvd_write: cover property (wr && rsvd);
   c_den1_write: cover property (wr && reg_addr == 7'h46);
endmodule // afc_chk

/* tb_top.sv */
// self-checking bench for the filter-coefficient register bank
// assumes afc_coeff_regs and afc_chk are compiled before it
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [6:0] a; logic [7:0] rst; logic [7:0] wd;} afc_row_t;
   logic        clk, reset_n, reg_page_sel, reg_wr_en, reg_rd_en;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wr_data, reg_rd_data, right_deemph_den1_low;
   logic        reg_hit, reg_rd_valid, reg_wr_refused;
   logic [15:0] atten, num0, num1, den1;
   logic [4:0]  coeff_updated;
   int          num_errors, comparisons;
   afc_row_t    rows [9] = '{'{7'h34, 8'h7E, 8'hA1}, '{7'h35, 8'h7F, 8'h80},
      '{7'h36, 8'hFF, 8'h00}, '{7'h41, 8'h39, 8'h7F}, '{7'h42, 8'h55, 8'hFF},
      '{7'h43, 8'hF3, 8'h12}, '{7'h44, 8'h2D, 8'h34}, '{7'h45, 8'h53, 8'hFE},
      '{7'h46, 8'h7E, 8'hDC}};
   afc_coeff_regs uut (.clk(clk), .reset_n(reset_n),
      .reg_page_sel(reg_page_sel), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
      .reg_hit(reg_hit), .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid), .reg_wr_refused(reg_wr_refused),
      .right_deemph_den1_low(right_deemph_den1_low),
      .stereo_widening_atten(atten), .left_hpf_numerator_zero(num0),
      .left_hpf_numerator_one(num1), .left_hpf_denominator_one(den1),
      .coeff_updated(coeff_updated));
   task final_report;
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   // strobes last exactly one edge; returns at the negedge after it
   task go(input logic w, input logic r, input logic [6:0] a,
           input logic [7:0] d);
      @(negedge clk);
      reg_wr_en = w;
      reg_rd_en = r;
      reg_addr = a;
      reg_wr_data = d;
      @(negedge clk);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
   endtask
   task rd(input logic [6:0] a, input logic [7:0] exp);
      go(1'b0, 1'b1, a, 8'h00);
      chk(reg_rd_valid, 1'b1, "no read valid");
      chk(reg_rd_data, exp, "read data");
   endtask
   task do_reset;
      reset_n = 1'b0;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #80000;
      num_errors++;
      final_report;
   end
   initial begin
      {reg_page_sel, reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
      do_reset;
      reg_page_sel = 1'b1;
      chk(atten, 16'h7FFF, "atten reset");
      chk(num0, 16'h3955, "num0 reset");
      chk(num1, 16'hF32D, "num1 reset");
      chk(den1, 16'h537E, "den1 reset");
      foreach (rows[i]) begin
         rd(rows[i].a, rows[i].rst);
         go(1'b1, 1'b0, rows[i].a, rows[i].wd);
         rd(rows[i].a, rows[i].wd);
      end
      chk(right_deemph_den1_low, 8'hA1, "den1 low out");
      chk(atten, 16'h8000, "atten min");
      chk(num0, 16'h7FFF, "num0 max");
      chk(num1, 16'h1234, "num1 joined");
      chk(den1, 16'hFEDC, "den1 joined");
      $display("test table done");
      for (int a = 8'h37; a <= 8'h40; a++) rd(a[6:0], 8'h00);
      go(1'b1, 1'b0, 7'h3A, 8'h5A);
      chk(reg_wr_refused, 1'b1, "no refusal");
      rd(7'h3A, 8'h00);
      $display("test reserved done");
      reg_page_sel = 1'b0;
      go(1'b1, 1'b1, 7'h35, 8'h11);
      chk(reg_rd_valid, 1'b0, "off-page answered");
      reg_page_sel = 1'b1;
      go(1'b0, 1'b1, 7'h47, 8'h00);
      chk({reg_hit, reg_rd_valid}, 2'b00, "outside bank hit");
      rd(7'h35, 8'h80);
      go(1'b1, 1'b1, 7'h36, 8'h42);
      chk(reg_rd_data, 8'h00, "same-edge read not old");
      rd(7'h36, 8'h42);
      $display("test edge cases done");
      do_reset;
      rd(7'h35, 8'h7F);
      chk(den1, 16'h537E, "den1 after reset");
      $display("test second reset done");
      final_report;
   end
endmodule // tb_top
bind afc_coeff_regs afc_chk chk_i (.clk(clk), .reset_n(reset_n),
   .reg_page_sel(reg_page_sel), .reg_wr_en(reg_wr_en),
   .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
   .reg_hit(reg_hit), .reg_rd_data(reg_rd_data),
   .reg_rd_valid(reg_rd_valid), .reg_wr_refused(reg_wr_refused),
   .right_deemph_den1_low(right_deemph_den1_low),
   .stereo_widening_atten(stereo_widening_atten),
   .left_hpf_numerator_zero(left_hpf_numerator_zero),
   .left_hpf_numerator_one(left_hpf_numerator_one),
   .left_hpf_denominator_one(left_hpf_denominator_one),
   .coeff_updated(coeff_updated));
